// ### rtl/ief_map.vh
// Register offsets, field positions and limits of the error-flag and rate block.
// Assumes a register port driven by the serial front end on the same clock.
// Function
// - A read of the error-flag word returns it, then clears all bits except those set in the read cycle.
// - Each flag is sticky until a read of the error-flag word clears it.
// - A condition still present after the clearing read sets its flag again.
// - Self-test finishing with any sensor failed sets flag bit 5.
// - Supply below 2.8 V sets bit 4 and halts data; recovery restarts.
// - Frame clock count not a multiple of 16 sets the serial error flag.
// - Failed flash update sets flag bit 2.
// - Data-path overrun sets bit 1; host then resets the device.
// - In scaled sync mode, loss of sync with the external clock sets bit 7.
// - Flash CRC mismatch after flash test sets its own flag, bit 6.
// - Each gyro axis rate is 32-bit two's complement, split high and low words.
// - High-word scale is 160, 40 or 10 LSB per deg/s by range model.
// - High word: zero 0x0000, one step 0x0001, full scale 0x4e20 and 0xb1e0.
// - Combined form: LSB is 1/65536 step; full scale 0x4e200000 and 0xb1e00000.
`ifndef IEF_MAP_VH
`define IEF_MAP_VH
`define IEF_ADDR_FLAGS 7'h02
`define IEF_ADDR_XG_LOW 7'h04
`define IEF_ADDR_XG_HIGH 7'h06
`define IEF_ADDR_YG_LOW 7'h08
`define IEF_ADDR_YG_HIGH 7'h0a
`define IEF_ADDR_ZG_LOW 7'h0c
`define IEF_ADDR_ZG_HIGH 7'h0e
`define IEF_ADDR_MISC_CTRL 7'h60
`define IEF_MISC_CTRL_RESET 16'h00c1
`define IEF_SYNC_MODE_SCALED 3'b010
`define IEF_BIT_SYNC_LOSS 7
`define IEF_BIT_CRC_FAIL 6
`define IEF_BIT_SENSOR_FAIL 5
`define IEF_BIT_LOW_SUPPLY 4
`define IEF_BIT_SERIAL_ERR 3
`define IEF_BIT_FLASH_UPD_FAIL 2
`define IEF_BIT_OVERRUN 1
`define IEF_FLAGS_RESET 16'h0000
`define IEF_FLAGS_USED 16'h00fe
`define IEF_FRAME_BITS 16
`define IEF_SCALE_125 8'd160
`define IEF_SCALE_500 8'd40
`define IEF_SCALE_2000 8'd10
`define IEF_POS_FULL_HIGH 16'h4e20
`define IEF_NEG_FULL_HIGH 16'hb1e0
`endif

// ### rtl/ief_rate_fmt.v
// Gyro rate formatter for three axes.
// Assumes raw samples already at the combined 32-bit scale, valid on a strobe.
`timescale 1ns/1ps
module ief_rate_fmt (
  input wire clk_sys,
  input wire reset,
  input wire hold,
  input wire sample_valid,
  input wire [95:0] sample_xyz,
  output wire [95:0] rate_xyz
);
`include "ief_map.vh"
  reg [95:0] rate_r;
  genvar g;
  // ----------------------------------------
  // Per-axis capture
  // ----------------------------------------
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      // Both halves load together, never one alone
      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          rate_r[g*32 +: 32] <= 32'h0000_0000;
        end else if (sample_valid && !hold) begin
          rate_r[g*32 +: 32] <= sample_xyz[g*32 +: 32];
        end
      end
    end
  endgenerate
  assign rate_xyz = rate_r;
endmodule // ief_rate_fmt

// ### rtl/ief_top.v
// Error-flag word and gyro rate output registers.
// Assumes a 16-bit register port on clk_sys; only supply_low, sync_lost and path_overrun may be asynchronous.
`timescale 1ns/1ps
module ief_top (
  input wire clk_sys,
  input wire reset,
  input wire reg_rd,
  input wire reg_wr,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire frame_end,
  input wire [7:0] frame_sclk_cnt,
  input wire self_test_done,
  input wire self_test_fail,
  input wire flash_test_done,
  input wire flash_crc_mismatch,
  input wire flash_update_done,
  input wire flash_update_fail,
  input wire supply_low,
  input wire sync_lost,
  input wire path_overrun,
  input wire sample_valid,
  input wire [95:0] sample_xyz,
  output wire data_halt
);
`include "ief_map.vh"
  // ----------------------------------------
  // Synchronisers for pin-side conditions
  // ----------------------------------------
  reg [1:0] sup_meta_r;
  reg [1:0] sup_sync_r;
  reg [1:0] syn_meta_r;
  reg [1:0] syn_sync_r;
  reg [1:0] ovr_meta_r;
  reg [1:0] ovr_sync_r;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sup_meta_r <= 2'b00;
      sup_sync_r <= 2'b00;
      syn_meta_r <= 2'b00;
      syn_sync_r <= 2'b00;
      ovr_meta_r <= 2'b00;
      ovr_sync_r <= 2'b00;
    end else begin
      sup_meta_r <= {1'b0, supply_low};
      sup_sync_r <= sup_meta_r;
      syn_meta_r <= {1'b0, sync_lost};
      syn_sync_r <= syn_meta_r;
      ovr_meta_r <= {1'b0, path_overrun};
      ovr_sync_r <= ovr_meta_r;
    end
  end
  wire sup_low_s = sup_sync_r[0];
  wire sync_lost_s = syn_sync_r[0];
  wire overrun_s = ovr_sync_r[0];

  // ----------------------------------------
  // Miscellaneous control word
  // ----------------------------------------
  reg [15:0] misc_ctrl_r;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      misc_ctrl_r <= `IEF_MISC_CTRL_RESET;
    end else if (reg_wr && reg_addr == `IEF_ADDR_MISC_CTRL) begin
      misc_ctrl_r <= reg_wdata;
    end
  end
  wire scaled_sync = (misc_ctrl_r[4:2] == `IEF_SYNC_MODE_SCALED);

  // ----------------------------------------
  // Flag set terms
  // ----------------------------------------
  // Level conditions re-raise every cycle they persist
  reg [15:0] flag_set;
  always @* begin
    flag_set = 16'h0000;
    flag_set[`IEF_BIT_SYNC_LOSS] = scaled_sync && sync_lost_s;
    flag_set[`IEF_BIT_CRC_FAIL] = flash_test_done && flash_crc_mismatch;
    flag_set[`IEF_BIT_SENSOR_FAIL] = self_test_done && self_test_fail;
    flag_set[`IEF_BIT_LOW_SUPPLY] = sup_low_s;
    // Low four bits zero means a whole number of 16-clock words
    flag_set[`IEF_BIT_SERIAL_ERR] = frame_end && (frame_sclk_cnt[3:0] != 4'h0);
    flag_set[`IEF_BIT_FLASH_UPD_FAIL] = flash_update_done && flash_update_fail;
    flag_set[`IEF_BIT_OVERRUN] = overrun_s;
  end

  // ----------------------------------------
  // Sticky error-flag word
  // ----------------------------------------
  reg [15:0] flags_r;
  reg [15:0] flags_nxt;
  wire flags_rd = reg_rd && (reg_addr == `IEF_ADDR_FLAGS);
  always @* begin
    flags_nxt = flags_r;
    if (flags_rd) begin
      flags_nxt = 16'h0000;
    end
    // Set wins over a same-cycle clear so no event is lost
    flags_nxt = (flags_nxt | flag_set) & `IEF_FLAGS_USED;
  end
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_r <= `IEF_FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Processing stops while supply is low, resumes on its own after
  assign data_halt = sup_low_s;

  // ----------------------------------------
  // Rate outputs
  // ----------------------------------------
  wire [95:0] rate_xyz;
  ief_rate_fmt u_rate (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold(data_halt),
    .sample_valid(sample_valid),
    .sample_xyz(sample_xyz),
    .rate_xyz(rate_xyz)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // High word carries the range-model scale set upstream
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `IEF_ADDR_FLAGS: reg_rdata <= flags_r;
        `IEF_ADDR_XG_LOW: reg_rdata <= rate_xyz[15:0];
        `IEF_ADDR_XG_HIGH: reg_rdata <= rate_xyz[31:16];
        `IEF_ADDR_YG_LOW: reg_rdata <= rate_xyz[47:32];
        `IEF_ADDR_YG_HIGH: reg_rdata <= rate_xyz[63:48];
        `IEF_ADDR_ZG_LOW: reg_rdata <= rate_xyz[79:64];
        `IEF_ADDR_ZG_HIGH: reg_rdata <= rate_xyz[95:80];
        `IEF_ADDR_MISC_CTRL: reg_rdata <= misc_ctrl_r;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // ief_top

// ### bench/ief_host_model.sv
// Host-side frame source for the error-flag block.
// Assumes calls are made just after a rising clk_sys edge.
`timescale 1ns/1ps
module ief_host_model (
  input wire clk_sys,
  output reg frame_end,
  output reg [7:0] frame_sclk_cnt
);
  initial {frame_end, frame_sclk_cnt} = 9'h000;
  task send(input [7:0] n);
    begin
      frame_end = 1'b1;
      frame_sclk_cnt = n;
      @(posedge clk_sys) #1;
      frame_end = 1'b0;
      // Count is stale once the frame is over
      frame_sclk_cnt = ~n;
    end
  endtask
endmodule // ief_host_model

// ### bench/ief_top_chk.sv
// Port-level checker for the error-flag block.
// Assumes binding to ief_top.
`timescale 1ns/1ps
module ief_chk (
  input wire clk_sys,
  input wire reset,
  input wire reg_rd,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_rdata,
  input wire frame_end,
  input wire [7:0] frame_sclk_cnt,
  input wire self_test_done,
  input wire self_test_fail,
  input wire flash_test_done,
  input wire flash_crc_mismatch,
  input wire flash_update_done,
  input wire flash_update_fail,
  input wire supply_low,
  input wire path_overrun,
  input wire data_halt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire rdf = reg_rd && reg_addr == 7'h02;
  AST_RSVD: assert property (rdf |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[0])
    else $error("reserved bit set");
  // Four held cycles cover the two sync stages, the flag register and the read-data register
  AST_OVR: assert property (path_overrun [*4] ##0 rdf |=> reg_rdata[1])
    else $error("overrun flag lost");
  AST_LOW: assert property (supply_low [*4] ##0 rdf |=> reg_rdata[4])
    else $error("supply flag lost");
  AST_HALT: assert property ($rose(supply_low) |-> ##[1:4] data_halt)
    else $error("no halt");
  AST_ST: assert property (self_test_done && self_test_fail ##1 rdf |=> reg_rdata[5])
    else $error("self-test flag lost");
  AST_CRC: assert property (flash_test_done && flash_crc_mismatch ##1 rdf |=> reg_rdata[6])
    else $error("crc flag lost");
  AST_UPD: assert property (flash_update_done && flash_update_fail ##1 rdf |=> reg_rdata[2])
    else $error("update flag lost");
  AST_SER: assert property (frame_end && frame_sclk_cnt[3:0] != 4'h0 ##1 rdf |=> reg_rdata[3])
    else $error("serial flag lost");
  cover property (rdf && supply_low);
  cover property ($rose(data_halt));
  cover property (frame_end && frame_sclk_cnt[3:0] == 4'h0);
endmodule // ief_chk

// ### bench/ief_top_tb.sv
// Self-checking bench for the error-flag word and gyro rate registers.
// Assumes ief_top, ief_chk and ief_host_model compiled first.
`timescale 1ns/1ps
module ief_top_tb;
  reg clk_sys, reset, reg_rd, reg_wr, self_test_done, self_test_fail, flash_test_done;
  reg flash_crc_mismatch, flash_update_done, flash_update_fail, supply_low, sync_lost;
  reg path_overrun, sample_valid;
  reg [6:0] reg_addr;
  reg [15:0] reg_wdata, got;
  reg [95:0] sample_xyz;
  wire [15:0] reg_rdata;
  wire [7:0] frame_sclk_cnt;
  wire frame_end, data_halt;
  integer n_fail = 0, num_checks = 0, cyc = 0, i;
  ief_top dut_u (.*);
  ief_host_model host_u (.*);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_sys) #1;
  endtask
  task rc(input [6:0] a, input [15:0] exp);
    begin
      reg_rd = 1'b1;
      reg_addr = a;
      idle(1);
      reg_rd = 1'b0;
      idle(1);
      chk(reg_rdata, exp);
    end
  endtask
  initial begin
    {clk_sys, reg_rd, reg_wr, self_test_done, self_test_fail, flash_test_done, flash_crc_mismatch,
      flash_update_done, flash_update_fail, supply_low, sync_lost, path_overrun, sample_valid,
      reg_addr, reg_wdata, sample_xyz} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 reset = 1'b0;
    rc(7'h60, 16'h00c1);
    reg_wr = 1'b1;
    reg_addr = 7'h02;
    reg_wdata = 16'hffff;
    idle(1);
    reg_wr = 1'b0;
    rc(7'h02, 16'h0000);
    {self_test_fail, flash_crc_mismatch, flash_update_fail} = 3'h7;
    for (i = 0; i < 3; i = i + 1) begin
      {self_test_done, flash_test_done, flash_update_done} = 3'h4 >> i;
      idle(1);
      {self_test_done, flash_test_done, flash_update_done} = 3'h0;
      rc(7'h02, i == 0 ? 16'h0020 : i == 1 ? 16'h0040 : 16'h0004);
    end
    rc(7'h02, 16'h0000);
    host_u.send(8'h11);
    rc(7'h02, 16'h0008);
    host_u.send(8'h20);
    rc(7'h02, 16'h0000);
    path_overrun = 1'b1;
    idle(4);
    rc(7'h02, 16'h0002);
    path_overrun = 1'b0;
    // Synchronised overrun re-raises the flag after the read; let it drain
    idle(3);
    rc(7'h02, 16'h0002);
    supply_low = 1'b1;
    idle(4);
    chk({15'h0000, data_halt}, 16'h0001);
    rc(7'h02, 16'h0010);
    rc(7'h02, 16'h0010);
    supply_low = 1'b0;
    sync_lost = 1'b1;
    idle(4);
    chk({15'h0000, data_halt}, 16'h0000);
    // Supply flag was re-raised after the last read; sync loss ignored outside scaled mode
    rc(7'h02, 16'h0010);
    reg_wr = 1'b1;
    reg_addr = 7'h60;
    reg_wdata = 16'h0008;
    idle(4);
    reg_wr = 1'b0;
    rc(7'h02, 16'h0080);
    reset = 1'b1;
    idle(1);
    reset = 1'b0;
    rc(7'h02, 16'h0000);
    sample_xyz = {32'hb1e00000, 32'h00000001, 32'h4e200000};
    sample_valid = 1'b1;
    idle(1);
    sample_valid = 1'b0;
    idle(2);
    for (i = 0; i < 6; i = i + 1)
      rc(7'h04 + {i[5:0], 1'b0}, sample_xyz[16 * i +: 16]);
    report_and_stop;
  end
endmodule // ief_top_tb
bind ief_top ief_chk chk_u (.*);
